// ===== logic/osc_select_pkg.sv
package osc_select_pkg;

  // Oscillator configuration options, fixed by the configuration straps.
  typedef enum logic [1:0] {
    CFG_EXT_FAST_CRYSTAL = 2'b00,
    CFG_EXT_RC_OSC       = 2'b01,
    CFG_INT_FAST_RC      = 2'b10,
    CFG_FAST_RC_WATCH    = 2'b11
  } osc_mode_t;

  // Frequency choice of the internal fast RC oscillator.
  typedef enum logic [1:0] {
    FAST_RC_4MHZ  = 2'b00,
    FAST_RC_8MHZ  = 2'b01,
    FAST_RC_12MHZ = 2'b10
  } fast_rc_freq_t;

  // System clock source as seen by the clock gate.
  typedef enum logic [2:0] {
    SRC_EXT_FAST_CRYSTAL = 3'b000,
    SRC_EXT_RC_OSC       = 3'b001,
    SRC_INT_FAST_RC      = 3'b010,
    SRC_WATCH_CRYSTAL    = 3'b011
  } sysclk_src_t;

  // Switch sequencer states.
  typedef enum logic [1:0] {
    SW_RUN      = 2'b00,
    SW_GATE_OFF = 2'b01,
    SW_SETTLE   = 2'b10
  } switch_state_t;

  typedef struct packed {
    osc_mode_t     mode;
    fast_rc_freq_t fast_rc_freq;
    logic          slow_rc_disable;
  } osc_cfg_t;

  typedef struct packed {
    logic ext_fast_crystal;
    logic ext_rc_osc;
    logic int_fast_rc;
    logic watch_crystal_osc;
    logic int_slow_rc;
  } osc_en_t;

  typedef struct packed {
    logic osc_in_pin_used;
    logic osc_out_pin_used;
    logic port_a_bit5_io;
    logic port_a_bit6_io;
  } pin_use_t;

  // Register map, byte addresses.
  localparam logic [11:0] ADDR_SYSTEM_CONTROL_FIRST = 12'h000;
  localparam logic [11:0] ADDR_CLOCK_STATUS         = 12'h004;

  // Field positions in the first system control register.
  localparam int          BIT_SLOW_SYSCLK_SELECT     = 0;
  localparam int          BIT_WATCH_XTAL_POWER_SAVE  = 1;
  localparam logic        RST_SLOW_SYSCLK_SELECT     = 1'b0;
  localparam logic        RST_WATCH_XTAL_POWER_SAVE  = 1'b0;

  // Field positions in the clock status register.
  localparam int          ST_SRC_LSB   = 0;
  localparam int          ST_GATE      = 3;
  localparam int          ST_BUSY      = 4;
  localparam int          ST_SLEEP     = 5;
  localparam int          ST_EN_LSB    = 8;
  localparam int          ST_MODE_LSB  = 16;
  localparam int          ST_FREQ_LSB  = 18;
  localparam int          ST_SLOWDIS   = 20;

  // Cycles the switch sequencer spends in SW_GATE_OFF between two sources.
  localparam int          GATE_GAP_CYCLES = 2;

endpackage : osc_select_pkg

// ===== logic/sysclk_switch.sv
// Break-before-make sequencer for the system clock source.
module sysclk_switch
  import osc_select_pkg::*;
#(
  parameter int GAP = GATE_GAP_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic want_slow,
  output logic      active_slow,
  output logic      gate_en,
  output logic      busy
);

  localparam int CW = $clog2(GAP + 1);

  switch_state_t   state;
  switch_state_t   next_state;
  logic [CW-1:0]   gap_cnt;
  wire             gap_done = (gap_cnt == CW'(GAP - 1));
  wire             mismatch = (want_slow != active_slow);

  // The old source is gated off first; only after the gap does the new one take over.
  always_comb begin
    next_state = state;
    case (state)
      SW_RUN:      if (mismatch) next_state = SW_GATE_OFF;
      SW_GATE_OFF: if (gap_done) next_state = SW_SETTLE;
      SW_SETTLE:   next_state = SW_RUN;
      default:     next_state = SW_RUN;
    endcase
  end

  // State, gap counter and the committed source advance together.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= SW_RUN;
      gap_cnt     <= '0;
      active_slow <= 1'b0;
    end else if (ce) begin
      state   <= next_state;
      gap_cnt <= (state == SW_GATE_OFF) ? gap_cnt + 1'b1 : '0;
      if (state == SW_GATE_OFF && gap_done) begin
        active_slow <= want_slow;
      end
    end
  end

  // The gate reopens only in the run state, so no runt pulse can leak out.
  assign gate_en = (state == SW_RUN) && !mismatch;
  assign busy    = (state != SW_RUN) || mismatch;

  // Source may only change while the gate has been shut for the whole gap.
  a_source_change_gated: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(active_slow) |-> $past(state) == SW_GATE_OFF && !$past(gate_en))
    else $error("clock source changed while gate open");

endmodule : sysclk_switch

// ===== logic/system_oscillator_select.sv
module system_oscillator_select
  import osc_select_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  // APB slave.
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // Configuration straps and power mode requests.
  input  wire osc_cfg_t      cfg_straps,
  input  wire logic          halt_req,
  input  wire logic          wake_req,
  // Oscillator control and clock routing.
  output osc_en_t            osc_en,
  output fast_rc_freq_t      fast_rc_freq,
  output logic               watch_xtal_power_save,
  output pin_use_t           pin_use,
  output sysclk_src_t        sysclk_src,
  output logic               sysclk_gate_en,
  output logic               watchdog_clk_slow_rc,
  output logic               watchdog_clk_watch,
  output logic               time_base_clk_watch,
  output logic               sleeping
);

  // Straps are caught once after reset release, never through the reset itself.
  osc_cfg_t cfg;
  logic     cfg_valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg       <= '{mode: CFG_EXT_FAST_CRYSTAL, fast_rc_freq: FAST_RC_4MHZ, slow_rc_disable: 1'b0};
      cfg_valid <= 1'b0;
    end else if (ce && !cfg_valid) begin
      cfg       <= cfg_straps;
      cfg_valid <= 1'b1;
    end
  end

  // APB decode; the slave answers in the access cycle, with wait states only while ce is low.
  wire        apb_access  = psel && penable && ce;
  wire        hit_ctrl    = (paddr == ADDR_SYSTEM_CONTROL_FIRST);
  wire        hit_status  = (paddr == ADDR_CLOCK_STATUS);
  wire        hit_any     = hit_ctrl || hit_status;
  wire        wr_ctrl     = apb_access && pwrite && hit_ctrl;
  wire        rd_strobe   = apb_access && !pwrite;

  // Control register bits.
  logic       slow_sysclk_select;
  logic       power_save;

  // Both bits are plain read/write and clear at reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_sysclk_select <= RST_SLOW_SYSCLK_SELECT;
      power_save         <= RST_WATCH_XTAL_POWER_SAVE;
    end else if (wr_ctrl) begin
      slow_sysclk_select <= pwdata[BIT_SLOW_SYSCLK_SELECT];
      power_save         <= pwdata[BIT_WATCH_XTAL_POWER_SAVE];
    end
  end

  // The power save bit only trims crystal current; it gates nothing.
  assign watch_xtal_power_save = power_save;

  // Configuration decode.
  wire        mode_crystal = (cfg.mode == CFG_EXT_FAST_CRYSTAL);
  wire        mode_ext_rc  = (cfg.mode == CFG_EXT_RC_OSC);
  wire        mode_fast_rc = (cfg.mode == CFG_INT_FAST_RC) || (cfg.mode == CFG_FAST_RC_WATCH);
  wire        has_watch    = (cfg.mode == CFG_FAST_RC_WATCH);

  // Slow select only counts in the fast RC plus watch crystal configuration.
  wire        want_slow    = slow_sysclk_select && has_watch;

  // Sleep state: entered by halt, left by any wake source.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleeping <= 1'b0;
    end else if (ce) begin
      if (wake_req) begin
        sleeping <= 1'b0;
      end else if (halt_req && cfg_valid) begin
        sleeping <= 1'b1;
      end
    end
  end

  // Break-before-make source switch between fast RC and watch crystal.
  logic       active_slow;
  logic       sw_gate_en;
  logic       sw_busy;

  sysclk_switch #(
    .GAP (GATE_GAP_CYCLES)
  ) u_switch (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (ce),
    .want_slow   (want_slow),
    .active_slow (active_slow),
    .gate_en     (sw_gate_en),
    .busy        (sw_busy)
  );

  // Next oscillator enables; fast sources stop in sleep and once slow mode has taken over.
  osc_en_t    next_osc_en;
  assign next_osc_en.ext_fast_crystal  = cfg_valid && mode_crystal && !sleeping;
  assign next_osc_en.ext_rc_osc        = cfg_valid && mode_ext_rc && !sleeping;
  assign next_osc_en.int_fast_rc       = cfg_valid && mode_fast_rc && !sleeping && !active_slow;
  assign next_osc_en.watch_crystal_osc = cfg_valid && has_watch;
  assign next_osc_en.int_slow_rc       = cfg_valid && !cfg.slow_rc_disable;

  // Pin ownership for each configuration.
  pin_use_t   next_pin_use;
  assign next_pin_use.osc_in_pin_used  = cfg_valid && (mode_crystal || mode_ext_rc || has_watch);
  assign next_pin_use.osc_out_pin_used = cfg_valid && (mode_crystal || has_watch);
  assign next_pin_use.port_a_bit5_io   = !next_pin_use.osc_out_pin_used;
  assign next_pin_use.port_a_bit6_io   = !next_pin_use.osc_in_pin_used;

  // Source routing for the system clock gate.
  sysclk_src_t next_src;
  assign next_src = mode_crystal ? SRC_EXT_FAST_CRYSTAL :
                    mode_ext_rc  ? SRC_EXT_RC_OSC :
                    active_slow  ? SRC_WATCH_CRYSTAL : SRC_INT_FAST_RC;

  // The gate closes in sleep and during any source change.
  wire        next_gate = cfg_valid && !sleeping && sw_gate_en;

  // Watchdog clock routing prefers the slow RC and falls back to the crystal; the time base takes the crystal only while the crystal is enabled.
  wire        next_wdt_slow  = next_osc_en.int_slow_rc;
  wire        next_wdt_watch = !next_osc_en.int_slow_rc && next_osc_en.watch_crystal_osc;
  wire        next_tb_watch  = next_osc_en.watch_crystal_osc;

  // All clock controls leave from flip-flops so the analogue side sees no decode glitches.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_en               <= '0;
      pin_use              <= '{osc_in_pin_used: 1'b0, osc_out_pin_used: 1'b0,
                                port_a_bit5_io: 1'b1, port_a_bit6_io: 1'b1};
      sysclk_src           <= SRC_EXT_FAST_CRYSTAL;
      sysclk_gate_en       <= 1'b0;
      fast_rc_freq         <= FAST_RC_4MHZ;
      watchdog_clk_slow_rc <= 1'b0;
      watchdog_clk_watch   <= 1'b0;
      time_base_clk_watch  <= 1'b0;
    end else if (ce) begin
      osc_en               <= next_osc_en;
      pin_use              <= next_pin_use;
      sysclk_src           <= next_src;
      sysclk_gate_en       <= next_gate;
      fast_rc_freq         <= cfg.fast_rc_freq;
      watchdog_clk_slow_rc <= next_wdt_slow;
      watchdog_clk_watch   <= next_wdt_watch;
      time_base_clk_watch  <= next_tb_watch;
    end
  end

  // Read data; reserved bits read as zero and an unmapped address reads zero with an error.
  logic [31:0] ctrl_word;
  logic [31:0] status_word;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[BIT_SLOW_SYSCLK_SELECT]    = slow_sysclk_select;
    ctrl_word[BIT_WATCH_XTAL_POWER_SAVE] = power_save;
    status_word = '0;
    status_word[ST_SRC_LSB +: 3]  = sysclk_src;
    status_word[ST_GATE]          = sysclk_gate_en;
    status_word[ST_BUSY]          = sw_busy;
    status_word[ST_SLEEP]         = sleeping;
    status_word[ST_EN_LSB +: 5]   = osc_en;
    status_word[ST_MODE_LSB +: 2] = cfg.mode;
    status_word[ST_FREQ_LSB +: 2] = cfg.fast_rc_freq;
    status_word[ST_SLOWDIS]       = cfg.slow_rc_disable;
  end

  wire [31:0] rd_mux = hit_ctrl ? ctrl_word : hit_status ? status_word : '0;

  // Read data is registered at the setup edge and held until the next read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && ce && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // The clock enable freezes the bus too, so pready drops while it is low.
  assign pready  = ce;
  assign pslverr = psel && penable && !hit_any;

  a_power_save_reset: assert property (@(posedge pclk)
    $rose(presetn) |-> !watch_xtal_power_save)
    else $error("power save bit not clear after reset");

  a_ctrl_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> watch_xtal_power_save == $past(pwdata[BIT_WATCH_XTAL_POWER_SAVE]))
    else $error("power save bit did not take written value");

  a_watch_runs_asleep: assert property (@(posedge pclk) disable iff (!presetn)
    ce && sleeping && has_watch ##1 ce |-> osc_en.watch_crystal_osc && !osc_en.int_fast_rc)
    else $error("sleep oscillator state wrong");

  a_sleep_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
    sleeping && ce |=> !sysclk_gate_en)
    else $error("system clock running in sleep");

  a_fast_pins_free: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_valid && cfg.mode == CFG_INT_FAST_RC && ce |=> pin_use.port_a_bit5_io && pin_use.port_a_bit6_io)
    else $error("fast RC mode claimed an oscillator pin");

  a_ext_rc_pins: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_valid && mode_ext_rc && ce |=> pin_use.port_a_bit5_io && !pin_use.port_a_bit6_io)
    else $error("external RC pin use wrong");

  a_slow_stops_fast: assert property (@(posedge pclk) disable iff (!presetn)
    active_slow && ce |=> !osc_en.int_fast_rc && sysclk_src == SRC_WATCH_CRYSTAL)
    else $error("fast RC not stopped in slow mode");

  a_slow_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    !has_watch |-> !active_slow)
    else $error("slow mode taken without watch crystal");

  a_switch_deadline: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(want_slow) && ce ##1 ce[*4] |-> active_slow || !want_slow)
    else $error("source switch did not complete");

  a_slow_rc_option: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_valid && cfg.slow_rc_disable && ce |=> !osc_en.int_slow_rc && !watchdog_clk_slow_rc)
    else $error("slow RC running although disabled");

  a_watch_mode_free: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_valid && has_watch && ce |=> osc_en.watch_crystal_osc)
    else $error("watch crystal stopped");

  // The clock enable holds every register, the bus read data included.
  a_ce_freeze_state: assert property (@(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(osc_en) && $stable(sysclk_gate_en) && $stable(sleeping) && $stable(prdata))
    else $error("state moved while clock enable low");

  // A crystal on the pins takes both of them from port A.
  a_crystal_pins: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_valid && mode_crystal && ce |=> pin_use.osc_in_pin_used && pin_use.osc_out_pin_used)
    else $error("crystal pins not claimed");

  // The fast RC frequency follows the strap once the straps are caught.
  a_fast_rc_freq: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_valid && ce |=> fast_rc_freq == $past(cfg.fast_rc_freq))
    else $error("fast RC frequency differs from strap");

  // A pin held by the timing network is never handed to port A as well.
  a_pins_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
    !(pin_use.osc_in_pin_used && pin_use.port_a_bit6_io) &&
    !(pin_use.osc_out_pin_used && pin_use.port_a_bit5_io))
    else $error("pin claimed twice");

  // The watch crystal claims both oscillator pins.
  a_watch_pins: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_valid && has_watch && ce |=> pin_use.osc_in_pin_used && pin_use.osc_out_pin_used)
    else $error("watch crystal pins not claimed");

  // Low-power mode only trims current, so the crystal keeps its enable.
  a_power_save_passive: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_valid && has_watch && watch_xtal_power_save && ce |=> osc_en.watch_crystal_osc)
    else $error("power save stopped the watch crystal");

  // Halt without a wake request puts the block to sleep on the next edge.
  a_halt_enters_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    halt_req && !wake_req && cfg_valid && ce |=> sleeping)
    else $error("halt did not enter sleep");

  // A wake request always ends sleep, even against a pending halt.
  a_wake_ends_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    wake_req && ce |=> !sleeping)
    else $error("wake did not leave sleep");

  // The time base keeps its crystal clock while the system clock is off.
  a_watch_in_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    sleeping && has_watch && ce |=> time_base_clk_watch && osc_en.watch_crystal_osc)
    else $error("time base lost its clock in sleep");

  // The watchdog never gets two clock sources at once.
  a_wdt_one_source: assert property (@(posedge pclk) disable iff (!presetn)
    !(watchdog_clk_slow_rc && watchdog_clk_watch))
    else $error("watchdog routed to two clocks");

  // Without the slow RC the watchdog falls back to the watch crystal.
  a_wdt_fallback: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_valid && cfg.slow_rc_disable && has_watch && ce |=> watchdog_clk_watch)
    else $error("watchdog fallback clock missing");

  // The slow RC keeps clocking the watchdog, in sleep too.
  a_slow_rc_runs: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_valid && !cfg.slow_rc_disable && ce |=> osc_en.int_slow_rc && watchdog_clk_slow_rc)
    else $error("slow RC not clocking the watchdog");

  // Sleep stops every fast oscillator.
  a_sleep_fast_off: assert property (@(posedge pclk) disable iff (!presetn)
    sleeping && ce |=> !osc_en.ext_fast_crystal && !osc_en.ext_rc_osc && !osc_en.int_fast_rc)
    else $error("fast oscillator running in sleep");

  // Outside slow mode both fast RC setups run the system from the fast RC.
  a_src_fast_rc: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_valid && mode_fast_rc && !active_slow && ce |=> sysclk_src == SRC_INT_FAST_RC)
    else $error("fast RC not selected as system clock");

  // The gate stays shut for as long as the sequencer reports a switch.
  a_gate_shut_busy: assert property (@(posedge pclk) disable iff (!presetn)
    sw_busy && ce |=> !sysclk_gate_en)
    else $error("gate open during a source switch");

  // Control read data shows both bits as they stood at the setup edge.
  a_ctrl_read_back: assert property (@(posedge pclk) disable iff (!presetn)
    rd_strobe && hit_ctrl && $past(ce) |-> prdata[BIT_SLOW_SYSCLK_SELECT] == slow_sysclk_select &&
      prdata[BIT_WATCH_XTAL_POWER_SAVE] == watch_xtal_power_save)
    else $error("control read data wrong");

  // A write to the status word is refused and leaves the control bits alone.
  a_status_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    apb_access && pwrite && hit_status |=> $stable(watch_xtal_power_save))
    else $error("status write changed a control bit");

endmodule : system_oscillator_select

// ===== testbench/osc_network_model.sv
// Far-side timing network: crystal, resonator or RC parts hung on the oscillator pins.
module osc_network_model
  import osc_select_pkg::*;
(
  input  wire osc_en_t  osc_en,
  input  wire pin_use_t pin_use,
  output logic          fault
);
  timeunit 1ns;
  timeprecision 1ps;
  // A crystal needs both pins, an RC network only the input pin, the fast RC none.
  wire xtal_bad  = osc_en.ext_fast_crystal && !(pin_use.osc_in_pin_used && pin_use.osc_out_pin_used);
  wire rc_bad    = osc_en.ext_rc_osc && !(pin_use.osc_in_pin_used && pin_use.port_a_bit5_io);
  wire watch_bad = osc_en.watch_crystal_osc && !(pin_use.osc_out_pin_used && pin_use.osc_in_pin_used);
  // A pin claimed both as I/O and by the tank would fight the parts on it.
  wire share_bad = (pin_use.osc_in_pin_used && pin_use.port_a_bit6_io) ||
                   (pin_use.osc_out_pin_used && pin_use.port_a_bit5_io);
  assign fault = xtal_bad | rc_bad | watch_bad | share_bad;
endmodule : osc_network_model

// ===== testbench/tb_system_oscillator_select.sv
module tb_system_oscillator_select;
  timeunit 1ns;
  timeprecision 1ps;
  import osc_select_pkg::*;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, halt_req = 0, wake_req = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic        pready, pslverr, watch_xtal_power_save, sysclk_gate_en, sleeping, fault, err, gate_low;
  logic        wd_slow, wd_watch, tb_watch;
  logic [31:0] prdata;
  osc_cfg_t    cfg_straps = '0;
  osc_en_t     osc_en;
  fast_rc_freq_t fast_rc_freq;
  pin_use_t    pin_use;
  sysclk_src_t sysclk_src;
  int bad_count = 0, check_count = 0, cyc = 0, m, f, dis, n;
  system_oscillator_select uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cfg_straps(cfg_straps), .halt_req(halt_req), .wake_req(wake_req), .osc_en(osc_en),
    .fast_rc_freq(fast_rc_freq), .watch_xtal_power_save(watch_xtal_power_save), .pin_use(pin_use),
    .sysclk_src(sysclk_src), .sysclk_gate_en(sysclk_gate_en), .watchdog_clk_slow_rc(wd_slow),
    .watchdog_clk_watch(wd_watch), .time_base_clk_watch(tb_watch), .sleeping(sleeping));
  osc_network_model partner (.osc_en(osc_en), .pin_use(pin_use), .fault(fault));
  always #20 pclk = ~pclk;
  // Hang guard; the whole run needs well under this many cycles.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      test_done();
    end
  end
  // Records any closed gate, so a switch that never breaks is caught.
  always @(posedge pclk) if (presetn && sysclk_gate_en !== 1'b1) gate_low <= 1'b1;
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic start(input int md, input int fq, input int ds);
    presetn <= 1'b0;
    cfg_straps <= '{mode: osc_mode_t'(md), fast_rc_freq: fast_rc_freq_t'(fq), slow_rc_disable: ds[0]};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : start
  // Reference model: oscillator enables and status word for each strap mode.
  function automatic int en_of(input int md, input int ds);
    int t[4] = '{16, 8, 4, 6};
    return t[md] + (ds ? 0 : 1);
  endfunction : en_of
  function automatic int st_of(input int md, input int fq, input int ds, input int en, input int src);
    return (ds << 20) + (fq << 18) + (md << 16) + (en << 8) + 8 + src;
  endfunction : st_of
  task automatic wait_idle();
    n = 0;
    do begin
      apb(1'b0, ADDR_CLOCK_STATUS, 32'h0);
      n = n + 1;
    end while (rd[ST_BUSY] !== 1'b0 && n < 20);
  endtask : wait_idle
  initial begin
    int pins[4] = '{12, 10, 3, 12};
    int srcs[4] = '{0, 1, 2, 2};
    void'($urandom(86));
    for (m = 0; m < 4; m++) for (f = 0; f < 3; f++) begin
      dis = $urandom % 2;
      start(m, f, dis);
      apb(1'b0, ADDR_SYSTEM_CONTROL_FIRST, 32'h0);
      chk(rd, 32'h0);
      chk(osc_en, en_of(m, dis));
      chk(pin_use, pins[m]);
      chk(fast_rc_freq, f);
      chk({wd_slow, wd_watch, tb_watch}, {dis == 0, dis == 1 && m == 3, m == 3});
      chk(fault, 1'b0);
      apb(1'b0, ADDR_CLOCK_STATUS, 32'h0);
      chk(rd, st_of(m, f, dis, en_of(m, dis), srcs[m]));
      // Slow select outside the paired mode is stored but must not move the clock.
      apb(1'b1, ADDR_SYSTEM_CONTROL_FIRST, {$urandom} << 2 | 32'h3);
      apb(1'b0, ADDR_SYSTEM_CONTROL_FIRST, 32'h0);
      chk(rd, 32'h3);
      chk(watch_xtal_power_save, 1'b1);
      if (m != 3) begin
        wait_idle();
        chk(sysclk_src, srcs[m]);
      end
    end
    // Paired mode: switch to the watch crystal and back, gate must break in between.
    start(3, 1, 0);
    gate_low = 1'b0;
    apb(1'b1, ADDR_SYSTEM_CONTROL_FIRST, 32'h1);
    wait_idle();
    repeat (2) @(posedge pclk);
    chk(sysclk_src, SRC_WATCH_CRYSTAL);
    chk(osc_en, 5'b00011);
    chk({gate_low, sysclk_gate_en}, 2'b11);
    apb(1'b1, ADDR_SYSTEM_CONTROL_FIRST, 32'h2);
    wait_idle();
    repeat (2) @(posedge pclk);
    chk(sysclk_src, SRC_INT_FAST_RC);
    // Sleep stops the fast clock; the watch crystal and slow RC run on.
    halt_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({sleeping, sysclk_gate_en, osc_en}, {2'b10, 5'b00011});
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({sleeping, sysclk_gate_en, osc_en}, {2'b01, 5'b00111});
    // Unmapped read, status write refused, and a stalled bus through ce.
    apb(1'b0, 12'h008, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, ADDR_CLOCK_STATUS, 32'hffffffff);
    apb(1'b0, ADDR_CLOCK_STATUS, 32'h0);
    chk(rd, st_of(3, 1, 0, 7, 2));
    ce <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(pready, 1'b0);
    ce <= 1'b1;
    // Let the frozen-state assertions finish their last attempts before the verdict.
    repeat (2) @(posedge pclk);
    test_done();
  end
endmodule : tb_system_oscillator_select
